// *** logic/pcs_pkg.sv ***
// Constants and types for the program counter sequencer.
// What this block does
// - Divide the system clock into four phases; one instruction cycle is four clocks.
// - Fetch the next instruction while the previous one executes.
// - Any program counter change costs two cycles: prefetch dropped, dummy cycle inserted.
// - Increment the program counter by one after each fetch.
// - A true skip discards the prefetch, runs a dummy cycle, continues at PC plus two.
// - Low byte readable and writable at 06H; a write jumps within the current page.
// - Jump, call, return, reset and interrupt load the full twelve-bit target.
// - Vectors: reset 000, external 004, timer0 008, timer1 00C, USB 010.
// - The program counter is twelve bits wide.
// - A start-up timer of 1024 system clocks runs before execution begins.
// - Sixteen-level return stack; a call when full overwrites the oldest entry.
// - With the stack full, interrupts stay pending until a return frees a level.
package pcs_pkg;
	localparam int PC_W = 12;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PAGE_W = PC_W - DATA_W;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W = 4;
	localparam int IRQ_N = 4;
	localparam logic [ADDR_W-1:0] PC_LOW_BYTE_ADDR = 8'h06;
	localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
	localparam logic [PC_W-1:0] VEC_EXT = 12'h004;
	localparam logic [PC_W-1:0] VEC_TMR0 = 12'h008;
	localparam logic [PC_W-1:0] VEC_TMR1 = 12'h00c;
	localparam logic [PC_W-1:0] VEC_USB = 12'h010;
	localparam logic [PC_W-1:0] PC_ONE = 12'h001;
	localparam logic [PC_W-1:0] PC_TWO = 12'h002;
	localparam int STARTUP_TSYS = 1024;
	localparam int STARTUP_CYC = STARTUP_TSYS;
	localparam int STARTUP_W = 11;
	localparam logic [STARTUP_W-1:0] STARTUP_LAST = 11'h3ff;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [3:0] PHASE_RESET = 4'h1;
	localparam logic [SP_W:0] COUNT_FULL = 5'h10;
	// Opcode classes delivered by the decoder with each executed instruction.
	typedef enum logic [2:0] {
		PCS_OP_NONE = 3'h0,
		PCS_OP_SKIP = 3'h1,
		PCS_OP_JUMP = 3'h2,
		PCS_OP_CALL = 3'h3,
		PCS_OP_RET = 3'h4
	} pcs_op_t;
	typedef enum logic [2:0] {
		PCS_ST_START = 3'b001,
		PCS_ST_RUN = 3'b010,
		PCS_ST_DUMMY = 3'b100
	} pcs_state_t;
endpackage : pcs_pkg

// *** logic/pcs_sequencer.sv ***
// Program counter sequencer: phases, fetch address, return stack and low byte register.
//
// Local design decision: the plain strobed port.
module pcs_sequencer (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Program memory fetch.
	output logic [pcs_pkg::PC_W-1:0] fetch_addr,
	output logic fetch_strobe,
	input wire logic [14:0] fetch_word,
	output logic [14:0] instr_word,
	output logic instr_valid,
	// Decoded instruction of the executing cycle.
	input wire logic [2:0] exec_op,
	input wire logic skip_true,
	input wire logic [pcs_pkg::PC_W-1:0] jump_target,
	// Interrupt requests, already enabled and masked: ext, tmr0, tmr1, usb.
	input wire logic [pcs_pkg::IRQ_N-1:0] irq_req,
	output logic [pcs_pkg::IRQ_N-1:0] irq_ack,
	// Register port.
	input wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pcs_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [pcs_pkg::DATA_W-1:0] reg_rdata,
	// Status.
	output logic [3:0] phase_clk,
	output logic running,
	output logic stack_full,
	output logic [pcs_pkg::PC_W-1:0] pc
);
	import pcs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	pcs_state_t state;
	logic [1:0] phase;
	logic [STARTUP_W-1:0] startup_cnt;
	logic [PC_W-1:0] stack_entry_bits [STACK_DEPTH];
	logic [SP_W-1:0] sp;
	logic [SP_W:0] depth;
	logic cycle_end;
	logic pcl_hit;
	logic irq_take;
	logic [PC_W-1:0] irq_vec;
	logic [IRQ_N-1:0] irq_sel;
	logic [PC_W-1:0] next_pc;
	logic redirect;
	logic do_push;
	logic do_pop;
	// Top of the return stack; a return on an empty stack reads a stale entry harmlessly.
	logic [PC_W-1:0] ret_addr;

	// The entry just under the pointer is the most recent return address.
	assign ret_addr = stack_entry_bits[sp - 4'h1];

	function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] a, input logic [PC_W-1:0] b);
		pc_add = a + b;
	endfunction : pc_add

	// Classes that move the program counter on their own and so must not share a cycle.
	function automatic logic is_flow_op(input logic [2:0] op);
		is_flow_op = (op == PCS_OP_JUMP) || (op == PCS_OP_CALL) || (op == PCS_OP_RET);
	endfunction : is_flow_op

	assign cycle_end = (phase == PHASE_LAST);
	assign pcl_hit = reg_write && (reg_addr == PC_LOW_BYTE_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// Fixed-priority interrupt selection; gated while the stack is full.

	always_comb begin
		irq_sel = '0;
		irq_vec = VEC_EXT;
		if (irq_req[0]) begin
			irq_sel = 4'h1;
			irq_vec = VEC_EXT;
		end else if (irq_req[1]) begin
			irq_sel = 4'h2;
			irq_vec = VEC_TMR0;
		end else if (irq_req[2]) begin
			irq_sel = 4'h4;
			irq_vec = VEC_TMR1;
		end else if (irq_req[3]) begin
			irq_sel = 4'h8;
			irq_vec = VEC_USB;
		end
	end

	// Interrupts are taken only at a normal instruction boundary so a dummy cycle is never split.
	assign irq_take = (state == PCS_ST_RUN) && cycle_end && (|irq_req) && !stack_full
		&& !pcl_hit && !is_flow_op(exec_op);

	////////////////////////////////////////////////////////////////////////////////
	// Next fetch address.

	always_comb begin
		next_pc = pc_add(pc, PC_ONE);
		if (state == PCS_ST_RUN && cycle_end) begin
			if (irq_take) begin
				next_pc = irq_vec;
			end else if (pcl_hit) begin
				next_pc = {pc[PC_W-1:DATA_W], reg_wdata};
			end else begin
				case (exec_op)
					PCS_OP_JUMP, PCS_OP_CALL: begin
						next_pc = jump_target;
					end
					PCS_OP_RET: begin
						next_pc = ret_addr;
					end
					default: begin
						// A taken skip steps by one here; the dummy cycle adds the second step.
						next_pc = pc_add(pc, PC_ONE);
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control flags, kept apart from the address so each decision reads on its own.

	always_comb begin
		redirect = 1'b0;
		do_push = 1'b0;
		do_pop = 1'b0;
		if (state == PCS_ST_RUN && cycle_end) begin
			if (irq_take) begin
				redirect = 1'b1;
				do_push = 1'b1;
			end else if (pcl_hit) begin
				redirect = 1'b1;
			end else begin
				case (exec_op)
					PCS_OP_SKIP: begin
						redirect = skip_true;
					end
					PCS_OP_JUMP: begin
						redirect = 1'b1;
					end
					PCS_OP_CALL: begin
						redirect = 1'b1;
						do_push = 1'b1;
					end
					PCS_OP_RET: begin
						redirect = 1'b1;
						do_pop = 1'b1;
					end
					default: begin
						redirect = 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase divider and state.

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= '0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// The one-hot ring runs free so the phases stay aligned with the counter after reset.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_clk <= PHASE_RESET;
		end else begin
			phase_clk <= {phase_clk[2:0], phase_clk[3]};
		end
	end

	// The counter stops at its last value and is never reused, so no reload path is needed.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			startup_cnt <= '0;
		end else if (state == PCS_ST_START && startup_cnt != STARTUP_LAST) begin
			startup_cnt <= startup_cnt + 11'h001;
		end
	end

	// Execution starts only on a cycle boundary, so the first fetch sees a whole cycle.
	// A redirect always inserts exactly one dummy cycle before normal flow resumes.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= PCS_ST_START;
		end else begin
			case (state)
				PCS_ST_START: begin
					if (startup_cnt == STARTUP_LAST && cycle_end) begin
						state <= PCS_ST_RUN;
					end
				end
				PCS_ST_RUN: begin
					if (redirect) begin
						state <= PCS_ST_DUMMY;
					end
				end
				PCS_ST_DUMMY: begin
					if (cycle_end) begin
						state <= PCS_ST_RUN;
					end
				end
				default: begin
					state <= PCS_ST_START;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program counter and pipelined fetch.

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc <= VEC_RESET;
		end else if (state == PCS_ST_RUN && cycle_end) begin
			pc <= next_pc;
		end else if (state == PCS_ST_DUMMY && cycle_end) begin
			pc <= pc_add(pc, PC_ONE);
		end
	end

	// The word is latched at the end of each cycle; after a redirect it is dropped.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			instr_word <= '0;
		end else if (cycle_end && state != PCS_ST_START) begin
			instr_word <= fetch_word;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			instr_valid <= 1'b0;
		end else if (cycle_end && state != PCS_ST_START) begin
			instr_valid <= !(state == PCS_ST_RUN && redirect);
		end
	end

	// The address lags the counter by one clock so memory sees a settled value.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_addr <= VEC_RESET;
		end else begin
			fetch_addr <= pc;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_strobe <= 1'b0;
		end else begin
			fetch_strobe <= (state != PCS_ST_START) && (phase == 2'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Return stack; a full stack wraps so the oldest entry is lost.

	// Calls and interrupts both save the address already being prefetched.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_entry_bits[i] <= '0;
			end
		end else if (do_push) begin
			stack_entry_bits[sp] <= pc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stack pointer and fill level.

	// The pointer wraps on purpose; a full stack silently loses its oldest entry.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sp <= '0;
		end else if (do_push) begin
			sp <= sp + 4'h1;
		end else if (do_pop && depth != '0) begin
			sp <= sp - 4'h1;
		end
	end

	// The fill level saturates so that one pop after an overflow clears the full flag.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			depth <= '0;
		end else if (do_push && depth != COUNT_FULL) begin
			depth <= depth + 5'h01;
		end else if (do_pop && depth != '0) begin
			depth <= depth - 5'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stack_full <= 1'b0;
		end else if (do_push) begin
			stack_full <= (depth >= COUNT_FULL - 5'h01);
		end else if (do_pop && depth != '0) begin
			stack_full <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt acknowledge.

	// Requests are levels held by their sources, so a refused one is simply taken later.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ack <= '0;
		end else begin
			irq_ack <= irq_take ? irq_sel : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port and status.

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_read && reg_addr == PC_LOW_BYTE_ADDR) begin
			reg_rdata <= pc[DATA_W-1:0];
		end else begin
			reg_rdata <= '0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			running <= 1'b0;
		end else begin
			running <= (state != PCS_ST_START);
		end
	end

endmodule : pcs_sequencer

// *** test/pcs_prog_mem.sv ***
// Program memory model for the sequencer bench.
module pcs_prog_mem (
	// Fetch side.
	input wire logic [11:0] fetch_addr,
	output logic [14:0] fetch_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each word carries its own address, so a wrong fetch shows at once.
	assign fetch_word = {3'h5, fetch_addr};
endmodule : pcs_prog_mem

// *** test/pcs_sequencer_properties.sv ***
// Port assertions for the program counter sequencer.
module pcs_seq_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Watched ports.
	input wire logic [11:0] pc,
	input wire logic [11:0] fetch_addr,
	input wire logic [11:0] jump_target,
	input wire logic fetch_strobe,
	input wire logic instr_valid,
	input wire logic running,
	input wire logic reg_read,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] exec_op,
	input wire logic [3:0] irq_req,
	input wire logic [3:0] irq_ack,
	input wire logic [3:0] phase_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	logic [10:0] age;
	logic p3;
	assign p3 = phase_clk[3] & running;
	// Saturates, so a long run cannot wrap it below the start-up figure.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			age <= 11'h000;
		end else if (age != 11'h7ff) begin
			age <= age + 11'h001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet;
		!fetch_strobe [*3];
	endsequence
	sequence s_redirect;
		pc == $past(jump_target) && !instr_valid;
	endsequence
	//////////////////////////////
	chk_phase_rotate: assert property (1'b1 |=> $onehot(phase_clk) &&
		phase_clk == {$past(phase_clk[2:0]), $past(phase_clk[3])}) else $error("bad phase");
	chk_strobe_gap: assert property (fetch_strobe |=> s_quiet) else $error("strobe gap");
	chk_fetch_follow: assert property (fetch_addr == $past(pc)) else $error("fetch addr");
	chk_read_low: assert property (reg_read && reg_addr == PC_LOW_BYTE_ADDR |=>
		reg_rdata == $past(pc[7:0])) else $error("low byte read");
	chk_read_unmapped: assert property (reg_read && reg_addr != PC_LOW_BYTE_ADDR |=>
		reg_rdata == 8'h00) else $error("unmapped read");
	chk_low_write: assert property (p3 && reg_write && reg_addr == PC_LOW_BYTE_ADDR &&
		exec_op == 3'h0 |=> pc == {$past(pc[11:8]), $past(reg_wdata)} && !instr_valid)
		else $error("low byte write");
	chk_jump_load: assert property (p3 && (exec_op == 3'h2 || exec_op == 3'h3)
		|=> s_redirect) else $error("jump target");
	chk_pc_step: assert property (p3 && exec_op == 3'h0 && !reg_write && irq_req == 4'h0
		|=> pc == $past(pc) + 12'h001) else $error("pc step");
	chk_irq_vector: assert property (irq_ack != 4'h0 |-> $onehot(irq_ack) && pc ==
		(irq_ack[0] ? VEC_EXT : irq_ack[1] ? VEC_TMR0 : irq_ack[2] ? VEC_TMR1 : VEC_USB)
		##1 irq_ack == 4'h0) else $error("irq vector");
	chk_start_wait: assert property (running |-> age >= 11'h400) else $error("early run");
endmodule : pcs_seq_checker
bind pcs_sequencer pcs_seq_checker i_pcs_seq_checker (.clk, .sys_rst, .pc, .fetch_addr,
	.jump_target, .fetch_strobe, .instr_valid, .running, .reg_read, .reg_write, .reg_addr,
	.reg_wdata, .reg_rdata, .exec_op, .irq_req, .irq_ack, .phase_clk);

// *** test/pcs_sequencer_tb.sv ***
// Self-checking bench for the program counter sequencer.
module pcs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] fetch_addr, pc;
	logic [11:0] jump_target = 12'h000;
	logic [14:0] fetch_word, instr_word;
	logic [2:0] exec_op = 3'h0;
	logic [3:0] irq_req = 4'h0;
	logic [3:0] irq_ack, phase_clk, seen;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic skip_true = 1'b0;
	logic fetch_strobe, instr_valid, running, stack_full;
	logic [11:0] vec [4] = '{VEC_EXT, VEC_TMR0, VEC_TMR1, VEC_USB};
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	always #12.5 clk = ~clk;
	pcs_sequencer i_pcs_sequencer (.clk, .sys_rst, .fetch_addr, .fetch_strobe, .fetch_word,
		.instr_word, .instr_valid, .exec_op, .skip_true, .jump_target, .irq_req, .irq_ack,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .phase_clk, .running,
		.stack_full, .pc);
	pcs_prog_mem i_pcs_prog_mem (.fetch_addr, .fetch_word);
	//////////////////////////////
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("FAIL t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	// Drives one decoded instruction into the phase-3 clock, when the sequencer samples it.
	task op(input logic [2:0] c, input logic [11:0] t, input logic k, input logic w);
		@(posedge clk);
		while (phase_clk !== 4'h4) @(posedge clk);
		exec_op <= c;
		jump_target <= t;
		skip_true <= k;
		reg_write <= w;
		reg_addr <= PC_LOW_BYTE_ADDR;
		reg_wdata <= t[7:0];
		@(posedge clk);
		exec_op <= 3'h0;
		skip_true <= 1'b0;
		reg_write <= 1'b0;
		#1;
	endtask : op
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		chk(pc, VEC_RESET);
		chk(phase_clk, 4'h1);
		sys_rst <= 1'b0;
		n = 0;
		while (running !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk(n > 1023 && n < 1040, 1'b1);
		$display("startup done");
		op(PCS_OP_JUMP, 12'h5a3, 1'b0, 1'b0);
		chk(pc, 12'h5a3);
		chk(instr_valid, 1'b0);
		rd(PC_LOW_BYTE_ADDR, 8'ha3);
		rd(8'h07, 8'h00);
		op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		chk(pc, 12'h5a5);
		op(PCS_OP_NONE, 12'h03c, 1'b0, 1'b1);
		chk(pc, 12'h53c);
		op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		op(PCS_OP_SKIP, 12'h000, 1'b1, 1'b0);
		chk(instr_valid, 1'b0);
		op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		op(PCS_OP_SKIP, 12'h000, 1'b0, 1'b0);
		chk(pc, 12'h540);
		chk(instr_valid, 1'b1);
		$display("flow done");
		op(PCS_OP_CALL, 12'h200, 1'b0, 1'b0);
		op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		op(PCS_OP_RET, 12'h000, 1'b0, 1'b0);
		chk(pc, 12'h540);
		op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		for (int j = 0; j < 16; j++) begin
			op(PCS_OP_CALL, 12'h300, 1'b0, 1'b0);
			op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		end
		chk(stack_full, 1'b1);
		@(posedge clk);
		irq_req <= 4'h1;
		seen = 4'h0;
		repeat (16) begin
			@(posedge clk);
			#1;
			seen = seen | irq_ack;
		end
		chk(seen, 4'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			irq_req <= 4'h1 << i;
			op(PCS_OP_RET, 12'h000, 1'b0, 1'b0);
			n = 0;
			while (irq_ack === 4'h0 && n < 40) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(irq_ack, 4'h1 << i);
			chk(pc, vec[i]);
			@(posedge clk);
			irq_req <= 4'h0;
			op(PCS_OP_NONE, 12'h000, 1'b0, 1'b0);
		end
		$display("stack done");
		test_done();
	end
endmodule : pcs_sequencer_tb
